// ---- hw/rfb_pkg.sv ----
/*
 * constants, states and carriers shared by the radio frame buffer block.
 * assumes a 50 MHz system clock and a byte-wide modem on the radio side.
 */
package rfb_pkg;
  // clock and timing
  localparam int CLK_NS        = 20;
  localparam int CLK_HZ        = 50_000_000;
  localparam int SYM_NS        = 16000;
  localparam int START_SYM     = 12;
  localparam int START_CYC     = START_SYM * SYM_NS / CLK_NS;
  localparam int SER_HZ        = 250_000;
  localparam int SER_HALF_CYC  = CLK_HZ / SER_HZ / 2;
  // frame layout
  localparam int BUF_DEPTH     = 128;
  localparam logic [6:0] LEN_MAX = 7'h7f;
  localparam int PREAMBLE_BYTES = 4;
  localparam logic [7:0] DELIM_BYTE = 8'ha7;
  localparam logic [7:0] PRE_BYTE   = 8'h00;
  localparam logic [15:0] FCS_POLY_REV = 16'h8408;
  localparam logic [15:0] FCS_INIT  = 16'h0000;
  // frame control field positions
  localparam int FCF_TYPE_LSB  = 0;
  localparam int FCF_SEC_BIT   = 3;
  localparam int FCF_PEND_BIT  = 4;
  localparam int FCF_ACK_BIT   = 5;
  localparam int FCF_PAN_BIT   = 6;
  localparam int FCF_DST_LSB   = 10;
  localparam int FCF_SRC_LSB   = 14;
  // data path modes
  localparam logic [1:0] MODE_BUF = 2'h0;
  localparam logic [1:0] MODE_SER = 2'h1;

  typedef enum logic [3:0] {
    T_IDLE = 4'h0, T_WAIT = 4'h1, T_PRE = 4'h2, T_SYNC = 4'h3, T_LEN = 4'h4,
    T_DATA = 4'h5, T_FCS0 = 4'h6, T_FCS1 = 4'h7, T_END = 4'h8, T_SER = 4'h9
  } rfb_tx_e;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic [7:0] data;
  } rfb_dem_s;

  typedef struct packed {
    logic [1:0] src_mode;
    logic [1:0] dst_mode;
    logic       intra_pan;
    logic       ack_req;
    logic       pending;
    logic       security;
    logic [2:0] ftype;
  } rfb_fcf_s;
endpackage

// ---- hw/rfb_crc.sv ----
/*
 * byte-wide frame checksum, reflected generator, data taken lsb first.
 * assumes the caller clears it before the first byte of each frame.
 */
`timescale 1ns/1ps
module rfb_crc
  import rfb_pkg::*;
(
  // clock and reset
  input  logic        clk,
  input  logic        resetn,
  // byte stream
  input  logic        clear,
  input  logic        en,
  input  logic [7:0]  data,
  // checksum
  output logic [15:0] crc_r,
  output logic [15:0] crc_nxt
);
  // eight serial steps of x^16+x^12+x^5+1, lsb first
  function automatic logic [15:0] step8(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c;
    for (int i = 0; i < 8; i++) begin
      v = (v[0] ^ d[i]) ? ((v >> 1) ^ FCS_POLY_REV) : (v >> 1);
    end
    return v;
  endfunction

  assign crc_nxt = step8(crc_r, data);

  // register, cleared per frame
  always_ff @(posedge clk) begin
    if (!resetn || clear) begin
      crc_r <= FCS_INIT;
    end else if (en) begin
      crc_r <= crc_nxt;
    end
  end
endmodule // rfb_crc

// ---- hw/rfb_skid.sv ----
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes both sides run on the same clock.
 */
`timescale 1ns/1ps
module rfb_skid #(
  parameter int W = 8
) (
  // clock and reset
  input  logic         clk,
  input  logic         resetn,
  // filling side
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  // draining side
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  logic         v1_r;
  logic [W-1:0] e1_r;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready = !v1_r;

  // head entry drives the outputs directly
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      v1_r      <= 1'b0;
      out_data  <= '0;
      e1_r      <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!out_valid) begin
            out_data  <= in_data;
            out_valid <= 1'b1;
          end else begin
            e1_r <= in_data;
            v1_r <= 1'b1;
          end
        end
        2'b01: begin
          out_data  <= e1_r;
          out_valid <= v1_r;
          v1_r      <= 1'b0;
        end
        2'b11: begin
          out_data <= v1_r ? e1_r : in_data;
          e1_r     <= in_data;
        end
        default: begin
        end
      endcase
    end
  end
endmodule // rfb_skid

// ---- hw/rfb_framer.sv ----
/*
 * frame builder, transmit and receive buffers, checksum and serial test mode.
 * assumes a byte-wide modulator and demodulator on the radio side and a host
 * that reaches the buffers through plain strobes and byte ports.
 */
`timescale 1ns/1ps
module rfb_framer
  import rfb_pkg::*;
#(
  parameter int START_WAIT = START_CYC,
  parameter int RX_THRESH  = 64
) (
  // clock and reset
  input  logic        clk,
  input  logic        resetn,
  // configuration
  input  logic        auto_checksum_enable,
  input  logic [1:0]  tx_mode,
  input  logic [1:0]  rx_mode,
  // command strobes
  input  logic        start_transmit_strobe,
  input  logic        start_transmit_if_clear_strobe,
  input  logic        flush_transmit_strobe,
  input  logic        flush_receive_strobe,
  input  logic        transmit_off_strobe,
  input  logic        channel_clear,
  // host byte ports
  input  logic        host_wr_valid,
  input  logic [7:0]  host_wr_data,
  input  logic [6:0]  host_ram_addr,
  output logic [7:0]  host_ram_data_r,
  output logic        rx_rd_valid,
  input  logic        rx_rd_ready,
  output logic [7:0]  rx_rd_data,
  // status
  output logic        tx_underflow_r,
  output logic        rx_overflow_r,
  output rfb_fcf_s    rx_fcf_r,
  // pins
  output logic        sfd_pin_r,
  output logic        rx_threshold_pin_r,
  input  logic        data_pin_in,
  output logic        data_pin_out_r,
  output logic        data_pin_oe_r,
  // radio side
  output logic [7:0]  mod_data_r,
  output logic        mod_valid_r,
  input  logic        mod_ready,
  input  rfb_dem_s    dem,
  input  logic [7:0]  rssi_avg,
  input  logic [6:0]  corr_avg
);
  localparam logic [13:0] WAIT_LD = 14'(START_WAIT - 1);
  localparam logic [7:0]  DEPTH8  = 8'(BUF_DEPTH);

  rfb_tx_e     tx_state_r;
  logic [7:0]  tx_mem [0:BUF_DEPTH-1];
  logic [7:0]  rx_mem [0:BUF_DEPTH-1];
  logic [7:0]  tx_wr_r, tx_rd_r, rx_wp_r, rx_rp_r, rx_cnt_r;
  logic [13:0] wait_r;
  logic [2:0]  pre_r, stx_bit_r, srx_bit_r;
  logic [6:0]  tx_left_r, rx_rem_r, rx_idx_r;
  logic        tx_done_r, tx_sfd_r, rx_in_r, rx_first_r, rx_frame_r;
  logic [7:0]  stx_sh_r, srx_sh_r;
  logic [7:0]  sdiv_r;
  logic        sclk_r;
  logic [2:0]  din_s_r;
  logic        din_r;
  logic [15:0] tx_crc, tx_crc_nx, rx_crc, rx_crc_nx;
  logic        skid_ready;

  // decode of strobes, pointers and byte selection
  wire        take     = !mod_valid_r || mod_ready;
  wire        go       = (start_transmit_strobe ||
                          (start_transmit_if_clear_strobe && channel_clear))
                         && tx_state_r == T_IDLE && tx_mode <= MODE_SER;
  wire        tx_ser   = tx_mode == MODE_SER;
  wire        rx_ser   = rx_mode == MODE_SER;
  wire        auto_fl  = tx_done_r && !tx_underflow_r;
  wire        wr_ok    = host_wr_valid && (auto_fl || tx_wr_r < DEPTH8) && !tx_ser;
  wire [7:0]  wr_idx   = auto_fl ? 8'h00 : tx_wr_r;
  wire [6:0]  len_w    = tx_mem[0][6:0];
  wire [6:0]  pay_w    = !auto_checksum_enable ? len_w :
                         (len_w < 7'h02) ? 7'h00 : 7'(len_w - 7'h02);
  wire        tx_avail = tx_rd_r < tx_wr_r;
  wire        tx_crc_en = tx_state_r == T_DATA && take && tx_left_r != 0 && tx_avail;
  wire        tx_crc_clr = tx_state_r == T_LEN && take;
  wire        ser_act  = tx_state_r == T_SER || (rx_ser && rx_in_r);
  wire        s_rise   = ser_act && sdiv_r == 8'(SER_HALF_CYC - 1) && !sclk_r;
  wire        s_fall   = ser_act && sdiv_r == 8'(SER_HALF_CYC - 1) && sclk_r;
  wire        rx_byte  = dem.valid && rx_in_r && !dem.sof;
  wire        rx_push_ok = rx_byte && !rx_ser && rx_cnt_r < DEPTH8 && !rx_overflow_r;
  wire        rx_pop   = rx_cnt_r != 0 && skid_ready;
  wire        crc_ok   = rx_crc_nx == 16'h0000;
  wire [7:0]  rx_store = !auto_checksum_enable ? dem.data :
                         rx_rem_r == 7'h02 ? rssi_avg :
                         rx_rem_r == 7'h01 ? {crc_ok, corr_avg} : dem.data;

  rfb_crc u_tx_crc (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (tx_crc_clr),
    .en      (tx_crc_en),
    .data    (tx_mem[tx_rd_r[6:0]]),
    .crc_r   (tx_crc),
    .crc_nxt (tx_crc_nx)
  );

  rfb_crc u_rx_crc (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (dem.valid && dem.sof),
    .en      (rx_byte && !rx_first_r),
    .data    (dem.data),
    .crc_r   (rx_crc),
    .crc_nxt (rx_crc_nx)
  );

  rfb_skid #(.W(8)) u_rx_skid (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (rx_cnt_r != 0),
    .in_ready  (skid_ready),
    .in_data   (rx_mem[rx_rp_r[6:0]]),
    .out_valid (rx_rd_valid),
    .out_ready (rx_rd_ready),
    .out_data  (rx_rd_data)
  );

  // buffer storage and random read without pointer change
  always_ff @(posedge clk) begin
    if (wr_ok) tx_mem[wr_idx[6:0]] <= host_wr_data;
    if (rx_push_ok) rx_mem[rx_wp_r[6:0]] <= rx_store;
    host_ram_data_r <= tx_mem[host_ram_addr];
  end

  // transmit sequencer and host write pointer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_state_r <= T_IDLE;
      tx_wr_r <= 8'h00; tx_rd_r <= 8'h00; tx_left_r <= 7'h00;
      wait_r <= 14'h0000; pre_r <= 3'h0; stx_bit_r <= 3'h0; stx_sh_r <= 8'h00;
      tx_done_r <= 1'b0; tx_sfd_r <= 1'b0; tx_underflow_r <= 1'b0;
      mod_data_r <= 8'h00; mod_valid_r <= 1'b0;
    end else begin
      if (mod_valid_r && mod_ready) mod_valid_r <= 1'b0;
      if (wr_ok) begin
        tx_wr_r <= wr_idx + 8'h01;
        tx_done_r <= 1'b0;
      end
      if (flush_transmit_strobe) begin
        tx_wr_r <= 8'h00;
        tx_done_r <= 1'b0;
        tx_underflow_r <= 1'b0;
      end
      case (tx_state_r)
        T_IDLE: if (go) begin
          tx_state_r <= T_WAIT;
          wait_r <= WAIT_LD;
          tx_rd_r <= 8'h00;
        end
        T_WAIT: if (wait_r == 14'h0000) begin
          tx_state_r <= T_PRE;
          pre_r <= 3'(PREAMBLE_BYTES - 1);
        end else begin
          wait_r <= wait_r - 14'h0001;
        end
        T_PRE: if (take) begin
          mod_data_r <= PRE_BYTE;
          mod_valid_r <= 1'b1;
          if (pre_r == 3'h0) tx_state_r <= T_SYNC;
          pre_r <= pre_r - 3'h1;
        end
        T_SYNC: if (take) begin
          mod_data_r <= DELIM_BYTE;
          mod_valid_r <= 1'b1;
          stx_bit_r <= 3'h0;
          tx_state_r <= tx_ser ? T_SER : T_LEN;
        end
        T_LEN: if (take) begin
          tx_sfd_r <= 1'b1;
          if (tx_wr_r == 8'h00) begin
            tx_underflow_r <= 1'b1;
            tx_sfd_r <= 1'b0;
            tx_state_r <= T_IDLE;
          end else begin
            mod_data_r <= tx_mem[0];
            mod_valid_r <= 1'b1;
            tx_rd_r <= 8'h01;
            tx_left_r <= pay_w;
            tx_state_r <= T_DATA;
          end
        end
        T_DATA: if (take) begin
          if (tx_left_r == 7'h00) begin
            tx_state_r <= auto_checksum_enable ? T_FCS0 : T_END;
          end else if (!tx_avail) begin
            tx_underflow_r <= 1'b1;
            tx_sfd_r <= 1'b0;
            tx_state_r <= T_IDLE;
          end else begin
            mod_data_r <= tx_mem[tx_rd_r[6:0]];
            mod_valid_r <= 1'b1;
            tx_rd_r <= tx_rd_r + 8'h01;
            tx_left_r <= tx_left_r - 7'h01;
          end
        end
        T_FCS0: if (take) begin
          mod_data_r <= tx_crc[7:0];
          mod_valid_r <= 1'b1;
          tx_state_r <= T_FCS1;
        end
        T_FCS1: if (take) begin
          mod_data_r <= tx_crc[15:8];
          mod_valid_r <= 1'b1;
          tx_state_r <= T_END;
        end
        T_END: if (take) begin
          tx_sfd_r <= 1'b0;
          tx_done_r <= 1'b1;
          tx_state_r <= T_IDLE;
        end
        T_SER: begin
          if (take && !mod_valid_r) tx_sfd_r <= 1'b1;
          if (s_rise) begin
            stx_sh_r <= {din_r, stx_sh_r[7:1]};
            stx_bit_r <= stx_bit_r + 3'h1;
            if (stx_bit_r == 3'h7) begin
              mod_data_r <= {din_r, stx_sh_r[7:1]};
              mod_valid_r <= 1'b1;
            end
          end
          if (transmit_off_strobe) begin
            tx_sfd_r <= 1'b0;
            tx_state_r <= T_IDLE;
          end
        end
        default: tx_state_r <= T_IDLE;
      endcase
    end
  end

  // receive framing, buffer pointers and overflow
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_in_r <= 1'b0; rx_first_r <= 1'b0; rx_frame_r <= 1'b0;
      rx_rem_r <= 7'h00; rx_idx_r <= 7'h00; rx_fcf_r <= '0;
      rx_wp_r <= 8'h00; rx_rp_r <= 8'h00; rx_cnt_r <= 8'h00;
      rx_overflow_r <= 1'b0; srx_sh_r <= 8'h00; srx_bit_r <= 3'h0;
    end else begin
      if (dem.valid && dem.sof) begin
        rx_in_r <= 1'b1;
        rx_first_r <= 1'b1;
      end else if (rx_byte) begin
        rx_first_r <= 1'b0;
        rx_idx_r <= rx_first_r ? 7'h00 : rx_idx_r + 7'h01;
        rx_rem_r <= rx_first_r ? dem.data[6:0] : rx_rem_r - 7'h01;
        if (rx_idx_r == 7'h00 && !rx_first_r) rx_fcf_r[6:0] <= dem.data[6:0];
        if (rx_idx_r == 7'h01) begin
          rx_fcf_r.dst_mode <= dem.data[FCF_DST_LSB-8 +: 2];
          rx_fcf_r.src_mode <= dem.data[FCF_SRC_LSB-8 +: 2];
        end
        if ((rx_first_r && dem.data[6:0] == 7'h00) || (!rx_first_r && rx_rem_r == 7'h01)) begin
          rx_in_r <= 1'b0;
          rx_frame_r <= !rx_ser;
        end
        if (rx_ser) begin
          srx_sh_r <= dem.data;
          srx_bit_r <= 3'h0;
        end
      end
      if (s_fall && rx_ser && tx_state_r != T_SER) begin
        srx_sh_r <= {1'b0, srx_sh_r[7:1]};
        srx_bit_r <= srx_bit_r + 3'h1;
      end
      if (rx_cnt_r == 8'h00 && !rx_push_ok) rx_frame_r <= 1'b0;
      if (rx_push_ok) rx_wp_r <= rx_wp_r + 8'h01;
      if (rx_pop) rx_rp_r <= rx_rp_r + 8'h01;
      rx_cnt_r <= rx_cnt_r + {7'h00, rx_push_ok} - {7'h00, rx_pop};
      if (flush_receive_strobe) begin
        rx_wp_r <= 8'h00; rx_rp_r <= 8'h00; rx_cnt_r <= 8'h00;
        rx_overflow_r <= 1'b0;
      end
      if (rx_byte && !rx_ser && rx_cnt_r == DEPTH8) rx_overflow_r <= 1'b1;
    end
  end

  // serial clock divider, data synchroniser and pins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sdiv_r <= 8'h00; sclk_r <= 1'b0; din_s_r <= 3'h0; din_r <= 1'b0;
      sfd_pin_r <= 1'b0; rx_threshold_pin_r <= 1'b0;
      data_pin_out_r <= 1'b0; data_pin_oe_r <= 1'b1;
    end else begin
      din_s_r <= {din_s_r[1:0], data_pin_in};
      if (din_s_r[1] == din_s_r[2]) din_r <= din_s_r[2];
      if (!ser_act) begin
        sdiv_r <= 8'h00;
        sclk_r <= 1'b0;
      end else if (sdiv_r == 8'(SER_HALF_CYC - 1)) begin
        sdiv_r <= 8'h00;
        sclk_r <= !sclk_r;
      end else begin
        sdiv_r <= sdiv_r + 8'h01;
      end
      sfd_pin_r <= tx_sfd_r || rx_in_r;
      rx_threshold_pin_r <= (tx_ser || rx_ser) ? sclk_r :
                            (rx_cnt_r >= 8'(RX_THRESH) || rx_frame_r);
      data_pin_oe_r <= !(tx_ser && !rx_ser);
      data_pin_out_r <= rx_ser ? srx_sh_r[0] : (rx_cnt_r != 8'h00);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  starve_stop_a: assert property ($rose(tx_underflow_r) |-> tx_state_r == T_IDLE && !tx_sfd_r)
    else $error("underflow did not stop transmit");
  starve_hold_a: assert property (tx_underflow_r && !flush_transmit_strobe |=> tx_underflow_r)
    else $error("starved flag cleared without flush");
  cca_busy_a: assert property (tx_state_r == T_IDLE && start_transmit_if_clear_strobe && !channel_clear
    && !start_transmit_strobe |=> tx_state_r == T_IDLE) else $error("busy channel started transmit");
  start_wait_a: assert property (go |=> tx_state_r == T_WAIT && wait_r == WAIT_LD)
    else $error("wrong start delay load");
  sfd_rise_a: assert property (tx_state_r == T_LEN && take && tx_wr_r != 0 |=> tx_sfd_r)
    else $error("delimiter pin not raised");
  fcs_low_a: assert property (tx_state_r == T_FCS0 && take
    |=> mod_data_r == $past(tx_crc[7:0]) && mod_valid_r) else $error("checksum low byte wrong");
  crc_flag_a: assert property (rx_push_ok && auto_checksum_enable && rx_rem_r == 7'h01
    |=> rx_mem[$past(rx_wp_r[6:0])][7] == $past(crc_ok)) else $error("crc status bit wrong");
  rssi_put_a: assert property (rx_push_ok && auto_checksum_enable && rx_rem_r == 7'h02
    |=> rx_mem[$past(rx_wp_r[6:0])] == $past(rssi_avg)) else $error("rssi not stored");
  clk_idle_a: assert property (!ser_act |=> sclk_r == 1'b0)
    else $error("serial clock ran while idle");
  auto_flush_a: assert property (wr_ok && auto_fl && !flush_transmit_strobe |=> tx_wr_r == 8'h01)
    else $error("auto flush missed");

  tx_done_c: cover property (tx_state_r == T_END ##1 tx_done_r);
  tx_starve_c: cover property ($rose(tx_underflow_r));
  rx_crc_c: cover property (rx_push_ok && auto_checksum_enable && rx_rem_r == 7'h01 && crc_ok);
  ser_clk_c: cover property (s_rise && tx_state_r == T_SER);
endmodule // rfb_framer

// ---- verif/rfb_radio_model.sv ----
/*
 * radio side model: modulator sink with random stalls, demodulator source.
 * assumes the framer clock and the byte handshake of its radio ports.
 */
`timescale 1ns/1ps
module rfb_radio_model
  import rfb_pkg::*;
(
  // clock
  input  logic       clk,
  // modulator side
  input  logic [7:0] mod_data_r,
  input  logic       mod_valid_r,
  output logic       mod_ready,
  // demodulator side
  output rfb_dem_s   dem
);
  logic [7:0] q[$];
  integer     seed = 32'h69bb;

  // idle at time zero
  initial begin
    mod_ready = 1'b0;
    dem = '0;
  end

  // stalling sink, a byte is taken on valid and ready
  always @(posedge clk) begin
    if (mod_valid_r && mod_ready) q.push_back(mod_data_r);
    mod_ready <= 1'($random(seed));
  end

  // delimiter beat, then bytes; idle data shows the inverse
  task automatic send(input logic [7:0] b[$]);
    dem <= '{1'b1, 1'b1, DELIM_BYTE};
    foreach (b[i]) begin
      @(posedge clk);
      dem <= '{1'b0, 1'b0, ~b[i]};
      repeat (3) @(posedge clk);
      dem <= '{1'b1, 1'b0, b[i]};
    end
    @(posedge clk);
    dem <= '{1'b0, 1'b0, ~b[b.size()-1]};
  endtask
endmodule // rfb_radio_model

// ---- verif/tb_top.sv ----
/*
 * self-checking bench for the frame buffer: transmit, resend, underflow, receive.
 * assumes the radio model beside it and a short start wait parameter.
 */
`timescale 1ns/1ps
module tb_top
  import rfb_pkg::*;
;
  logic       clk, resetn, ace, cc, wv, ready, rd_valid, und, ovf, sfd, thr, mvalid, mready;
  logic       din, toff, dpo, dpoe;
  logic [1:0] txm;
  logic [3:0] strb;
  logic [7:0] wd, rssi, ram_q, rd_data, mdata, sb;
  logic [6:0] addr, corr;
  rfb_fcf_s   fcf;
  rfb_dem_s   dem;
  logic [7:0] pl[$];
  logic [7:0] rq[$];
  integer     seed = 32'h69bb;
  int         errors = 0;
  int         n_tests = 0;

  rfb_framer #(.START_WAIT(20)) dut (
    .clk(clk), .resetn(resetn), .auto_checksum_enable(ace), .tx_mode(txm),
    .rx_mode(MODE_BUF), .start_transmit_strobe(strb[0]),
    .start_transmit_if_clear_strobe(strb[1]), .flush_transmit_strobe(strb[2]),
    .flush_receive_strobe(strb[3]), .transmit_off_strobe(toff), .channel_clear(cc),
    .host_wr_valid(wv), .host_wr_data(wd), .host_ram_addr(addr), .host_ram_data_r(ram_q),
    .rx_rd_valid(rd_valid), .rx_rd_ready(ready), .rx_rd_data(rd_data),
    .tx_underflow_r(und), .rx_overflow_r(ovf), .rx_fcf_r(fcf), .sfd_pin_r(sfd),
    .rx_threshold_pin_r(thr), .data_pin_in(din), .data_pin_out_r(dpo), .data_pin_oe_r(dpoe),
    .mod_data_r(mdata), .mod_valid_r(mvalid), .mod_ready(mready), .dem(dem),
    .rssi_avg(rssi), .corr_avg(corr));

  rfb_radio_model radio (
    .clk(clk), .mod_data_r(mdata), .mod_valid_r(mvalid), .mod_ready(mready), .dem(dem));

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // receive stream reader with random stalls
  always @(posedge clk) begin
    if (rd_valid && ready) rq.push_back(rd_data);
    ready <= 1'($random(seed));
  end

  task automatic summarize();
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] b);
    @(posedge clk);
    wv <= 1'b1;
    wd <= b;
    @(posedge clk);
    wv <= 1'b0;
  endtask

  task automatic strobe(input logic [3:0] s);
    @(posedge clk);
    strb <= s;
    @(posedge clk);
    strb <= '0;
  endtask

  // reflected checksum step, lsb first
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ FCS_POLY_REV : c >> 1;
    return c;
  endfunction

  task automatic waitq(input int n);
    for (int i = 0; i < 8000 && radio.q.size() < n; i++) @(posedge clk);
  endtask

  task automatic load(input int n);
    pl.delete();
    wr({1'b0, 7'(n)});
    for (int i = 0; i < n - 2; i++) begin
      pl.push_back(8'($random(seed)));
      wr(pl[i]);
    end
  endtask

  task automatic run(input logic [3:0] s);
    logic [15:0] c;
    c = FCS_INIT;
    radio.q.delete();
    strobe(s);
    repeat (19) @(posedge clk);
    chk(16'(radio.q.size()), 16'h0000);
    waitq(8);
    chk(16'(sfd), 16'h0001);
    waitq(pl.size() + 8);
    repeat (4) @(posedge clk);
    chk(16'(sfd), 16'h0000);
    for (int i = 0; i < PREAMBLE_BYTES; i++) chk(radio.q[i], PRE_BYTE);
    chk(radio.q[4], DELIM_BYTE);
    chk(radio.q[5], 8'(pl.size() + 2));
    foreach (pl[i]) begin
      chk(radio.q[6 + i], pl[i]);
      c = crc(c, pl[i]);
    end
    chk({radio.q[pl.size() + 7], radio.q[pl.size() + 6]}, c);
  endtask

  task automatic rxf(input int n, input logic good);
    logic [7:0]  b[$];
    logic [15:0] c;
    c = FCS_INIT;
    b.push_back(8'(n));
    rssi <= 8'($random(seed));
    corr <= 7'($random(seed));
    for (int i = 0; i < n - 2; i++) begin
      b.push_back(8'($random(seed)));
      c = crc(c, b[i + 1]);
    end
    b.push_back(c[7:0] ^ {7'h00, !good});
    b.push_back(c[15:8]);
    rq.delete();
    @(posedge clk);
    radio.send(b);
    // a complete stored frame raises the threshold pin
    for (int i = 0; i < 200 && thr !== 1'b1; i++) @(posedge clk);
    chk(16'(thr), 16'h0001);
    for (int i = 0; i < 8000 && rq.size() < n + 1; i++) @(posedge clk);
    for (int i = 0; i < n - 1; i++) chk(rq[i], b[i]);
    chk(rq[n - 1], rssi);
    chk(rq[n], {good, corr});
    chk(fcf, rfb_fcf_s'({b[2][7:6], b[2][3:2], b[1][6:0]}));
    // drained buffer: status pins idle, data pin driven
    repeat (3) @(posedge clk);
    chk(16'({thr, ovf, dpo}), 16'h0000);
    chk(16'(dpoe), 16'h0001);
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    ace = 1'b1;
    cc = 1'b0;
    wv = 1'b0;
    wd = '0;
    strb = '0;
    addr = '0;
    rssi = '0;
    corr = '0;
    ready = 1'b0;
    txm = MODE_BUF;
    din = 1'b0;
    toff = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    load(3 + ($random(seed) & 15));
    run(4'b0001);
    addr <= 7'h01;
    repeat (2) @(posedge clk);
    chk(ram_q, pl[0]);
    radio.q.delete();
    strobe(4'b0010);
    repeat (40) @(posedge clk);
    chk(16'(radio.q.size()), 16'h0000);
    cc <= 1'b1;
    run(4'b0010);
    wr(8'h0c);
    wr(8'h55);
    strobe(4'b0001);
    for (int i = 0; i < 2000 && und !== 1'b1; i++) @(posedge clk);
    chk(16'(und), 16'h0001);
    @(posedge clk);
    chk(16'(sfd), 16'h0000);
    strobe(4'b0100);
    @(posedge clk);
    chk(16'(und), 16'h0000);
    load(127);
    run(4'b0001);
    rxf(5 + ($random(seed) & 15), 1'b1);
    rxf(20, 1'b0);
    // serial transmit: host changes data after each falling clock edge
    txm <= MODE_SER;
    sb = 8'($random(seed));
    din <= sb[0];
    radio.q.delete();
    strobe(4'b0001);
    for (int i = 1; i < 8; i++) begin
      for (int k = 0; k < 400 && thr !== 1'b1; k++) @(posedge clk);
      for (int k = 0; k < 400 && thr !== 1'b0; k++) @(posedge clk);
      din <= sb[i];
    end
    waitq(6);
    chk(16'(dpoe), 16'h0000);
    chk(16'(sfd), 16'h0001);
    chk(radio.q[4], DELIM_BYTE);
    chk(radio.q[5], sb);
    toff <= 1'b1;
    @(posedge clk);
    toff <= 1'b0;
    txm <= MODE_BUF;
    strobe(4'b1000);
    summarize();
  end

  // watchdog
  initial begin
    #1_000_000;
    errors++;
    summarize();
  end
endmodule // tb_top
